// ==== mgri_pkg.sv ====
// Package for the general register group: offsets, fields, reset values.
package mgri_pkg;

  // ==========================================================
  // Register indices (byte-wide register address on the link)
  localparam logic [7:0] ADDR_LINK_RATE = 8'h07;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_PIN = 8'h09;
  localparam logic [7:0] ADDR_POWER_CFG = 8'h0A;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_COMMAND = 8'h03;
  localparam logic [7:0] ADDR_PART_ID = 8'h10;
  localparam logic [7:0] ADDR_FW_REV = 8'h11;
  localparam logic [7:0] ADDR_MAX_RATE = 8'h12;
  localparam logic [7:0] ADDR_FILL_COUNT = 8'hE9;

  // ==========================================================
  // Status and enable bit positions
  localparam int BIT_CREATED = 0;
  localparam int BIT_ACTIVATED = 1;
  localparam int BIT_DATA_READY = 8;
  localparam int BIT_ERROR = 16;
  localparam int BIT_BAD_CMD = 17;
  localparam int BIT_BAD_MODE = 18;
  localparam int BIT_CREATE_FAIL = 19;
  localparam int BIT_ACTIVATE_FAIL = 20;
  localparam int BIT_WRONG_STATE = 21;
  localparam logic [31:0] CLEARABLE_MASK = 32'hFFFFFF00;

  // ==========================================================
  // Reset values and codes
  localparam logic [31:0] LINK_RATE_RESET = 32'h0001C200;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [7:0] PIN_MODE_OFF = 8'h00;
  localparam logic [7:0] PIN_MODE_FOLLOW = 8'h01;
  localparam logic [31:0] CMD_CLEAR_STATUS = 32'h00000004;

  // Register request from the link front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mgri_req_t;

  // Register answer to the link front end
  typedef struct packed {
    logic valid;
    logic known;
    logic [31:0] rdata;
  } mgri_rsp_t;

endpackage

// ==== mgri_regs.sv ====
// General register group with interrupt qualification and host interrupt pin.
// How it works
// RULE_01: Rate register drives UART, resets 0x1C200.
// RULE_02: Read-only maximum supported bit rate register.
// RULE_03: Interrupt while any enabled status bit set.
// RULE_04: Enables for created, activated, data ready.
// RULE_05: Error enables at bits sixteen to twenty.
// RULE_06: Wrong-state access enable at bit 21.
// RULE_07: Pin mode zero keeps pin inactive.
// RULE_08: Pin mode one follows interrupt condition.
// RULE_09: Read/write module power configuration register.
// RULE_10: Firmware version as major, minor, patch.
// RULE_11: Read-only result buffer fill count.
// RULE_12: Command four clears clearable status bits.
// RULE_13: Host writes via 0xF9, address, value; the host model here sends whole register requests with no 0xF9 byte.
// RULE_14: Registers 32 bits; interrupt tracks in one cycle.
`timescale 1ns/100ps
`default_nettype none

module mgri_regs #(
  parameter logic [31:0] PART_ID = 32'h00005A5A, // Arbitrary identity value
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [7:0] FW_MINOR = 8'h00,
  parameter logic [7:0] FW_PATCH = 8'h00,
  parameter logic [31:0] MAX_RATE = 32'h001E8480
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire mgri_pkg::mgri_req_t req,
  output var mgri_pkg::mgri_rsp_t rsp,
  input wire logic [31:0] status_set,
  input wire logic [31:0] fill_count,
  output logic [31:0] link_rate,
  output logic [31:0] power_config,
  output logic [31:0] status,
  output logic irq_condition,
  output logic host_irq
);
  import mgri_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  logic [31:0] link_rate_r;
  logic [31:0] irq_enable_r;
  logic [31:0] irq_pin_r;
  logic [31:0] power_cfg_r;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  mgri_rsp_t rsp_r;
  mgri_rsp_t rsp_nxt;
  logic host_irq_r;

  wire logic wr = req.valid && req.write;
  wire logic wr_rate = wr && hit(req.addr, ADDR_LINK_RATE);
  wire logic wr_enable = wr && hit(req.addr, ADDR_IRQ_ENABLE);
  wire logic wr_pin = wr && hit(req.addr, ADDR_IRQ_PIN);
  wire logic wr_power = wr && hit(req.addr, ADDR_POWER_CFG);
  wire logic clr_cmd = wr && hit(req.addr, ADDR_COMMAND)
                       && (req.wdata == CMD_CLEAR_STATUS); // RULE_12
  wire logic [31:0] fw_word = {8'h00, FW_MAJOR, FW_MINOR, FW_PATCH}; // RULE_10

  // Set wins over clear so an event arriving with the acknowledge is kept
  assign status_nxt = (clr_cmd ? (status_r & ~CLEARABLE_MASK) : status_r)
                      | status_set; // RULE_12

  // Interrupt is purely combinational so it tracks mask and status at once
  assign irq_condition = |(status_r & irq_enable_r); // RULE_03 RULE_04 RULE_05 RULE_06 RULE_14

  // Read mux; unknown addresses answer zero with known low
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.valid = req.valid;
    rsp_nxt.known = 1'b1;
    case (req.addr)
      ADDR_LINK_RATE: rsp_nxt.rdata = link_rate_r;
      ADDR_IRQ_ENABLE: rsp_nxt.rdata = irq_enable_r;
      ADDR_IRQ_PIN: rsp_nxt.rdata = irq_pin_r;
      ADDR_POWER_CFG: rsp_nxt.rdata = power_cfg_r; // RULE_09
      ADDR_STATUS: rsp_nxt.rdata = status_r;
      ADDR_COMMAND: rsp_nxt.rdata = ZERO_WORD;
      ADDR_PART_ID: rsp_nxt.rdata = PART_ID;
      ADDR_FW_REV: rsp_nxt.rdata = fw_word; // RULE_10
      ADDR_MAX_RATE: rsp_nxt.rdata = MAX_RATE; // RULE_02
      ADDR_FILL_COUNT: rsp_nxt.rdata = fill_count; // RULE_11
      default: rsp_nxt.known = 1'b0;
    endcase
    if (req.write) begin
      rsp_nxt.rdata = ZERO_WORD;
    end
  end

  // ==========================================================
  // Writable registers; read-only addresses ignore writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link_rate_r <= LINK_RATE_RESET; // RULE_01
      irq_enable_r <= ZERO_WORD;
      irq_pin_r <= ZERO_WORD;
      power_cfg_r <= ZERO_WORD;
    end else if (clk_en) begin
      if (wr_rate) link_rate_r <= req.wdata; // RULE_01
      if (wr_enable) irq_enable_r <= req.wdata;
      if (wr_pin) irq_pin_r <= req.wdata;
      if (wr_power) power_cfg_r <= req.wdata; // RULE_09
    end
  end

  // Status, answer and pin flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_r <= ZERO_WORD;
      rsp_r <= '0;
      host_irq_r <= 1'b0;
    end else if (clk_en) begin
      status_r <= status_nxt;
      rsp_r <= rsp_nxt;
      host_irq_r <= (irq_pin_r[7:0] == PIN_MODE_FOLLOW) && irq_condition; // RULE_07 RULE_08
    end
  end

  assign rsp = rsp_r;
  assign link_rate = link_rate_r; // RULE_01
  assign power_config = power_cfg_r;
  assign status = status_r;
  assign host_irq = host_irq_r;

  // ==========================================================
  // Checks; each guards one register or the interrupt path above, except the freeze check, which guards four
  // Read strobes used by several checks below
  wire logic rd_fw = req.valid && !req.write && hit(req.addr, ADDR_FW_REV);
  wire logic rd_max = req.valid && !req.write && hit(req.addr, ADDR_MAX_RATE);
  wire logic rd_id = req.valid && !req.write && hit(req.addr, ADDR_PART_ID);
  wire logic rd_fill = req.valid && !req.write && hit(req.addr, ADDR_FILL_COUNT);

  // Reset value is seen at the first edge after release
  AST_RATE_RESET: assert property (@(posedge core_clk) // RULE_01
    $fell(reset) |-> link_rate == LINK_RATE_RESET)
    else $error("rate not at default after reset");

  // Combinational condition matches the masked status word
  AST_IRQ_COND: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    irq_condition == ((status & irq_enable_r) != ZERO_WORD))
    else $error("interrupt condition mismatch");

  // An empty mask never raises the condition
  AST_ZERO_MASK: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    irq_enable_r == ZERO_WORD |-> !irq_condition)
    else $error("interrupt with empty mask");

  // Pin mode zero keeps the host pin low
  AST_PIN_OFF: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    clk_en && irq_pin_r[7:0] == PIN_MODE_OFF |=> !host_irq)
    else $error("pin active in off mode");

  // Pin mode one copies the condition one cycle later
  AST_PIN_FOLLOW: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
    clk_en && irq_pin_r[7:0] == PIN_MODE_FOLLOW |=> host_irq == $past(irq_condition))
    else $error("pin does not follow interrupt");

  // Clear command with no new event empties the clearable upper three bytes
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (reset) // RULE_12
    clk_en && clr_cmd && status_set == ZERO_WORD |=> (status & CLEARABLE_MASK) == ZERO_WORD)
    else $error("clear command left bits");

  // The clear command never touches the low, non-clearable byte
  AST_LOW_KEPT: assert property (@(posedge core_clk) disable iff (reset) // RULE_12
    clk_en && clr_cmd |=> ($past(status) & ~CLEARABLE_MASK & ~status) == ZERO_WORD)
    else $error("low status bits lost on clear");

  // Without a clear command status bits are sticky
  AST_STICKY: assert property (@(posedge core_clk) disable iff (reset) // RULE_12
    clk_en && !clr_cmd |=> (status & $past(status)) == $past(status))
    else $error("status bit dropped without clear");

  // A wrong-state event taken with clock enable high is never lost, even beside a clear
  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
    clk_en && status_set[BIT_WRONG_STATE] |=> status[BIT_WRONG_STATE])
    else $error("event lost");

  // Data-ready event with its enable set raises the condition
  AST_DATA_READY: assert property (@(posedge core_clk) disable iff (reset) // RULE_04
    clk_en && !wr_enable && irq_enable_r[BIT_DATA_READY] && status_set[BIT_DATA_READY]
    |=> irq_condition)
    else $error("data ready did not interrupt");

  // Activation-failure event with its enable set raises the condition
  AST_ACT_FAIL: assert property (@(posedge core_clk) disable iff (reset) // RULE_05
    clk_en && !wr_enable && irq_enable_r[BIT_ACTIVATE_FAIL] && status_set[BIT_ACTIVATE_FAIL]
    |=> irq_condition)
    else $error("activation failure did not interrupt");

  // Writes land in the addressed register at the next edge
  AST_RATE_WRITE: assert property (@(posedge core_clk) disable iff (reset) // RULE_01
    clk_en && wr_rate |=> link_rate == $past(req.wdata))
    else $error("rate write lost");
  AST_ENABLE_WRITE: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    clk_en && wr_enable |=> irq_enable_r == $past(req.wdata))
    else $error("enable write lost");
  AST_PIN_WRITE: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    clk_en && wr_pin |=> irq_pin_r == $past(req.wdata))
    else $error("pin mode write lost");
  AST_POWER_WRITE: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    clk_en && wr_power |=> power_config == $past(req.wdata))
    else $error("power write lost");

  // Read-only words answer with their fixed or live values
  AST_FW_READ: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    clk_en && rd_fw |=> rsp.rdata == fw_word)
    else $error("version read wrong");
  AST_MAX_RO: assert property (@(posedge core_clk) disable iff (reset) // RULE_02
    clk_en && rd_max |=> rsp.rdata == MAX_RATE)
    else $error("max rate read wrong");
  AST_ID_READ: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    clk_en && rd_id |=> rsp.rdata == PART_ID)
    else $error("identity read wrong");
  AST_FILL_READ: assert property (@(posedge core_clk) disable iff (reset) // RULE_11
    clk_en && rd_fill |=> rsp.rdata == $past(fill_count))
    else $error("fill count read wrong");

  // Every taken request is answered one cycle later, writes with zero data
  AST_ANSWER: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    clk_en && req.valid |=> rsp.valid)
    else $error("request not answered");
  AST_NO_ANSWER: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    clk_en && !req.valid |=> !rsp.valid)
    else $error("answer without request");
  AST_WRITE_ZERO: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    clk_en && req.valid && req.write |=> rsp.rdata == ZERO_WORD)
    else $error("write answer carried data");

  // A low clock enable freezes every register, so no event slips in
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    !clk_en |=> $stable(status) && $stable(link_rate) && $stable(host_irq) && $stable(rsp))
    else $error("state moved while frozen");

  // Main scenarios worth seeing at least once
  COV_IRQ: cover property (@(posedge core_clk) disable iff (reset) $rose(host_irq));
  COV_CLEAR: cover property (@(posedge core_clk) disable iff (reset) clr_cmd && irq_condition);
  COV_UNMAPPED: cover property (@(posedge core_clk) disable iff (reset) rsp.valid && !rsp.known);
  COV_SET_CLEAR: cover property (@(posedge core_clk) disable iff (reset)
    clk_en && clr_cmd && status_set != ZERO_WORD);

endmodule
`default_nettype wire

// ==== mgri_host.sv ====
// Host model that issues whole register requests to the register group.
`timescale 1ns/100ps
`default_nettype none
module mgri_host (
  input wire logic core_clk,
  output var mgri_pkg::mgri_req_t req,
  input wire mgri_pkg::mgri_rsp_t rsp
);
  import mgri_pkg::*;
  logic [31:0] rd_data;
  logic rd_known;
  logic rd_valid;
  // ==========================================================
  // Request driver
  // Idle fields carry the inverse of the last request so stale data never matches
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    req <= {1'b1, wr, a, d};
    @(negedge core_clk);
    rd_data = rsp.rdata;
    rd_known = rsp.known;
    rd_valid = rsp.valid;
    req <= {1'b0, ~wr, ~a, ~d};
  endtask
  // Quiet bus from time zero
  initial req = '0;
endmodule
`default_nettype wire

// ==== test_module_general_regs_irq.sv ====
// Testbench for the general register group and host interrupt pin.
`timescale 1ns/100ps
`default_nettype none
module test_module_general_regs_irq;
  import mgri_pkg::*;
  localparam logic [31:0] MAXR = 32'h001E8480;
  localparam logic [31:0] PID = 32'h00005A5A; // Arbitrary identity value
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] status_set = '0;
  logic clk_en = 1'b1;
  logic [31:0] fill_count = 32'h00000123;
  mgri_req_t req;
  mgri_rsp_t rsp;
  logic [31:0] link_rate, power_config, status;
  logic irq_condition, host_irq;
  int error_cnt = 0;
  int tests_run = 0;
  int bits [9] = '{8, 16, 17, 18, 19, 20, 21, 0, 1};
  // Clock at 25 MHz
  always #20 core_clk = ~core_clk;
  mgri_regs #(.PART_ID(PID), .FW_MAJOR(8'h03), .FW_MINOR(8'h02), .FW_PATCH(8'h01),
    .MAX_RATE(MAXR)) u_mgri_regs (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .req(req), .rsp(rsp), .status_set(status_set), .fill_count(fill_count),
    .link_rate(link_rate), .power_config(power_config), .status(status),
    .irq_condition(irq_condition), .host_irq(host_irq));
  mgri_host u_mgri_host (.core_clk(core_clk), .req(req), .rsp(rsp));
  // ==========================================================
  // Compare and access tasks
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic k);
    u_mgri_host.access(1'b0, a, 32'h00000000);
    chk1("rsp_valid", 1'b1, u_mgri_host.rd_valid);
    chk1("rsp_known", k, u_mgri_host.rd_known);
    chk32("rdata", e, u_mgri_host.rd_data);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_mgri_host.access(1'b1, a, d);
  endtask
  // Status bit pulse, one cycle wide
  task automatic pulse(input int b);
    @(negedge core_clk);
    status_set[b] = 1'b1;
    @(negedge core_clk);
    status_set = '0;
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    rd(ADDR_LINK_RATE, LINK_RATE_RESET, 1'b1);
    chk32("link_rate", LINK_RATE_RESET, link_rate);
    wr(ADDR_MAX_RATE, 32'h00000001);
    rd(ADDR_MAX_RATE, MAXR, 1'b1);
    rd(ADDR_FW_REV, 32'h00030201, 1'b1);
    rd(ADDR_PART_ID, PID, 1'b1);
    rd(ADDR_FILL_COUNT, 32'h00000123, 1'b1);
    rd(8'h55, ZERO_WORD, 1'b0);
    wr(ADDR_LINK_RATE, 32'h0004B000);
    rd(ADDR_LINK_RATE, 32'h0004B000, 1'b1);
    chk32("link_rate", 32'h0004B000, link_rate);
    wr(ADDR_POWER_CFG, 32'hA5C3F00F);
    rd(ADDR_POWER_CFG, 32'hA5C3F00F, 1'b1);
    chk32("power_config", 32'hA5C3F00F, power_config);
    // Empty mask hides a pending data-ready bit until enabled
    wr(ADDR_IRQ_PIN, 32'h00000001);
    pulse(BIT_DATA_READY);
    chk1("irq_condition", 1'b0, irq_condition);
    wr(ADDR_IRQ_ENABLE, 32'h00000100);
    chk1("irq_condition", 1'b1, irq_condition);
    // Each enable bit alone, then the clear command; low bits survive it
    foreach (bits[i]) begin
      wr(ADDR_IRQ_ENABLE, 32'h00000001 << bits[i]);
      pulse(bits[i]);
      @(negedge core_clk);
      chk1("irq_condition", 1'b1, irq_condition);
      chk1("host_irq", 1'b1, host_irq);
      wr(ADDR_COMMAND, CMD_CLEAR_STATUS);
      @(negedge core_clk);
      chk1("host_irq", bits[i] < 8, host_irq);
    end
    wr(ADDR_IRQ_PIN, 32'h00000000);
    @(negedge core_clk);
    chk1("host_irq", 1'b0, host_irq);
    chk1("irq_condition", 1'b1, irq_condition);
    // Low bits survive; command reads as zero; mask and mode read back
    rd(ADDR_STATUS, 32'h00000003, 1'b1);
    rd(ADDR_COMMAND, ZERO_WORD, 1'b1);
    rd(ADDR_IRQ_ENABLE, 32'h00000002, 1'b1);
    rd(ADDR_IRQ_PIN, ZERO_WORD, 1'b1);
    // Event and clear command in one cycle: the event stays
    fork
      wr(ADDR_COMMAND, CMD_CLEAR_STATUS);
      pulse(BIT_BAD_CMD);
    join
    chk32("status", 32'h00020003, status);
    // Low clock enable drops nothing but takes no event either
    @(negedge core_clk);
    clk_en = 1'b0;
    pulse(BIT_WRONG_STATE);
    chk32("status", 32'h00020003, status);
    clk_en = 1'b1;
    pulse(BIT_WRONG_STATE);
    chk32("status", 32'h00220003, status);
    wrap_up();
  end
  // Watchdog, far beyond the roughly 130 cycles the sequence needs
  initial begin
    #(40 * 3000);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
